// *** design/dbmt_pkg.sv ***
// shared constants and types for the dma bus-master timing block
package dbmt_pkg;
    // commands written to the command register
    localparam logic [7:0] CMD_ENABLE_AFTER_RETURN_FROM_INTERRUPT = 8'hb7;
    localparam logic [7:0] CMD_ENABLE_TRANSFER = 8'h87;
    localparam logic [7:0] CMD_DISABLE_TRANSFER = 8'h83;
    // release modes
    localparam logic [1:0] MODE_BYTE = 2'h0;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
    localparam logic [1:0] MODE_BURST = 2'h2;
    // cycle lengths in t-states
    localparam logic [2:0] LEN_MIN = 3'h2;
    localparam logic [2:0] LEN_MAX = 3'h4;
    localparam logic [2:0] LEN_MEM_DEFAULT = 3'h3;
    localparam logic [2:0] LEN_IO_DEFAULT = 3'h4;
    // t-state at whose falling edge wait is sampled; zero means never
    localparam logic [2:0] WAIT_T_MEM = 3'h2;
    localparam logic [2:0] WAIT_T_IO_DEFAULT = 3'h3;
    localparam logic [2:0] WAIT_T_IO_VAR = 3'h3;
    localparam logic [2:0] WAIT_T_NONE = 3'h0;
    // strobe window positions in half t-states, pos = 2*t + phase
    localparam logic [3:0] POS_VAR_IO_START = 4'h2;
    localparam logic [3:0] POS_VAR_START = 4'h3;
    localparam logic [3:0] POS_MEM_START = 4'h3;
    localparam logic [3:0] POS_IO_START = 4'h4;
    // bit positions of the early-end fields
    localparam int EARLY_IO = 3;
    localparam int EARLY_MEM = 2;
    localparam int EARLY_RD = 1;
    localparam int EARLY_WR = 0;
    // consecutive low acknowledge samples before the first transfer
    localparam logic [1:0] ACK_SAMPLES = 2'h2;
    // reset values
    localparam logic [2:0] RST_T = 3'h1;
    localparam logic RST_PIN_HIGH = 1'b1;
    localparam logic [7:0] RST_DATA = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b011,
        ST_PARK = 3'b100,
        ST_DRAIN = 3'b101,
        ST_WAITREL = 3'b110
    } dbmt_state_t;
endpackage

// *** design/dbmt_sync.sv ***
// two flip-flop synchroniser for pins entering the core clock domain
`timescale 1ns/10ps
module dbmt_sync import dbmt_pkg::*; #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] sync
);
    logic [W-1:0] stage;

    // first stage feeds only the second; resets to the idle-high pin level
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage <= {W{RST_PIN_HIGH}};
            sync <= {W{RST_PIN_HIGH}};
        end else begin
            stage <= pin;
            sync <= stage;
        end
    end
endmodule

// *** design/dbmt_master.sv ***
// bus-master sequencing of a single-channel dma: cycles, request and release
`timescale 1ns/10ps
module dbmt_master import dbmt_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ready_pin,
    input wire logic bus_ack_in_n,
    input wire logic wait_n,
    input wire logic [7:0] data_in,
    input wire logic ready_high,
    input wire logic wait_mux_en,
    input wire logic [1:0] mode,
    input wire logic xfer_en,
    input wire logic stop_on_match,
    input wire logic int_on_ready,
    input wire logic src_is_io,
    input wire logic dst_is_io,
    input wire logic src_var,
    input wire logic dst_var,
    input wire logic [2:0] src_len,
    input wire logic [2:0] dst_len,
    input wire logic [3:0] src_early,
    input wire logic [3:0] dst_early,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic return_from_interrupt_seen,
    input wire logic match_in,
    input wire logic last_byte,
    output logic bus_request_out_n,
    output logic bus_ack_out_n,
    output logic io_request_strobe_n,
    output logic memory_request_strobe_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic int_req_n,
    output logic bus_master,
    output logic byte_done,
    output logic in_service_latch
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [10:0] pins_s;
    logic ready_s;
    logic ack_s_n;
    logic wait_s_n;
    logic [7:0] data_s;

    dbmt_sync #(.W(11)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin({data_in, wait_n, bus_ack_in_n, ready_pin}),
        .sync(pins_s)
    );
    assign {data_s, wait_s_n, ack_s_n} = pins_s[10:1];
    assign ready_s = (pins_s[0] == ready_high);

    // ****************************************************************
    // t-clock phase and cycle shape
    // ****************************************************************
    dbmt_state_t state;
    logic ph;
    logic [2:0] t;
    logic hold_t;
    logic [1:0] ack_cnt;
    logic match_flag;
    logic enabled;
    logic after_return_from_interrupt;
    logic go_ok;

    logic cur_io, cur_var, in_cyc, t_edge, cyc_end, last_cyc, start_req;
    logic [2:0] cur_len, cfg_len, wait_t;
    logic [3:0] cur_early, pos, gen_start;

    // the core clock runs at twice the t-clock so half-state edges are flops
    assign t_edge = ph;
    assign in_cyc = (state == ST_READ) || (state == ST_WRITE);
    assign cur_io = (state == ST_WRITE) ? dst_is_io : src_is_io;
    assign cur_var = (state == ST_WRITE) ? dst_var : src_var;
    assign cfg_len = (state == ST_WRITE) ? dst_len : src_len;
    assign cur_early = (state == ST_WRITE) ? dst_early : src_early;

    // variable length clamped into two..four states
    // fixed lengths when variable timing is off
    always_comb begin
        if (!cur_var) begin
            cur_len = cur_io ? LEN_IO_DEFAULT : LEN_MEM_DEFAULT;
        end else if (cfg_len < LEN_MIN) begin
            cur_len = LEN_MIN;
        end else if (cfg_len > LEN_MAX) begin
            cur_len = LEN_MAX;
        end else begin
            cur_len = cfg_len;
        end
    end

    // choose the state whose falling edge samples wait
    always_comb begin
        if (!cur_var) begin
            wait_t = cur_io ? WAIT_T_IO_DEFAULT : WAIT_T_MEM;
        end else if (cur_io) begin
            wait_t = (cur_len == LEN_MAX) ? WAIT_T_IO_VAR : WAIT_T_NONE;
        end else begin
            wait_t = (cur_len > LEN_MIN) ? WAIT_T_MEM : WAIT_T_NONE;
        end
    end

    assign cyc_end = in_cyc && ph && (t == cur_len) && !hold_t;
    assign last_cyc = (state == ST_WRITE) || (state == ST_READ && !xfer_en);
    assign pos = {t, ph};

    // ****************************************************************
    // t-state counter and wait extension
    // ****************************************************************
    // ph toggles always: it is the half-state divider
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ph <= 1'b0;
        end else begin
            ph <= ~ph;
        end
    end

    // wait sampled at the falling edge, the repeated state samples again
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_t <= 1'b0;
        end else if (in_cyc && !ph) begin
            hold_t <= wait_mux_en && (wait_t != WAIT_T_NONE) && (t == wait_t) && !wait_s_n;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            t <= RST_T;
        end else if (!in_cyc || cyc_end) begin
            t <= RST_T;
        end else if (ph && !hold_t) begin
            t <= t + 3'h1;
        end
    end

    // ****************************************************************
    // request, grant and release sequencing
    // ****************************************************************
    // a free bus is one whose acknowledge chain is idle high
    assign start_req = enabled && !in_service_latch && ready_s && ack_s_n
        && (!int_on_ready || go_ok);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else if (t_edge) begin
            unique case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        state <= ST_REQ;
                    end
                end
                // start on the edge after the second low sample
                ST_REQ: begin
                    if (ack_cnt == ACK_SAMPLES) begin
                        state <= ST_READ;
                    end
                end
                ST_READ, ST_WRITE: begin
                    if (cyc_end && !last_cyc) begin
                        state <= ST_WRITE;
                    // byte mode waits out the handshake
                    end else if (cyc_end && mode == MODE_BYTE) begin
                        state <= ST_WAITREL;
                    // end of block ends mastership at once
                    end else if (cyc_end && last_byte) begin
                        state <= ST_IDLE;
                    // match seen during this byte: release afterwards
                    end else if (cyc_end && stop_on_match && match_flag) begin
                        state <= ST_DRAIN;
                    // burst gives the bus back when not ready
                    end else if (cyc_end && !ready_s && mode == MODE_BURST) begin
                        state <= ST_DRAIN;
                    end else if (cyc_end && !ready_s) begin
                        state <= ST_PARK;
                    end else if (cyc_end) begin
                        state <= ST_READ;
                    end
                end
                ST_PARK: begin
                    if (ready_s) begin
                        state <= ST_READ;
                    end
                end
                ST_DRAIN: begin
                    state <= ST_WAITREL;
                end
                // wait for both request and acknowledge high
                ST_WAITREL: begin
                    if (ack_s_n && bus_request_out_n) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_cnt <= 2'h0;
        end else if (t_edge) begin
            if (state != ST_REQ || ack_s_n) begin
                ack_cnt <= 2'h0;
            end else if (ack_cnt != ACK_SAMPLES) begin
                ack_cnt <= ack_cnt + 2'h1;
            end
        end
    end

    // compare result for the previous byte arrives during this read
    // once set, ready cannot override the match release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            match_flag <= 1'b0;
        end else if (match_in) begin
            match_flag <= 1'b1;
        end else if (state == ST_IDLE) begin
            match_flag <= 1'b0;
        end
    end

    // bus request pin; a released bus stays released until idle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_request_out_n <= RST_PIN_HIGH;
        end else if (t_edge) begin
            // drive request low on the next edge
            if (state == ST_IDLE && start_req) begin
                bus_request_out_n <= 1'b0;
            // raise on the edge opening the final state of the byte
            end else if (in_cyc && mode == MODE_BYTE && last_cyc && !hold_t
                && t == cur_len - 3'h1) begin
                bus_request_out_n <= 1'b1;
            // same edge on which the final transfer completes
            // ready is not looked at inside the byte
            end else if (cyc_end && last_cyc && last_byte) begin
                bus_request_out_n <= 1'b1;
            // first edge after the byte completes
            end else if (state == ST_DRAIN) begin
                bus_request_out_n <= 1'b1;
            end
        end
    end

    // daisy chain: pass the grant on only when we do not want the bus
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_ack_out_n <= RST_PIN_HIGH;
        end else begin
            bus_ack_out_n <= ack_s_n || !bus_request_out_n || bus_master;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_master <= 1'b0;
            byte_done <= 1'b0;
        end else begin
            bus_master <= in_cyc || state == ST_PARK || state == ST_DRAIN;
            byte_done <= cyc_end && last_cyc;
        end
    end

    // ****************************************************************
    // strobes and data path
    // ****************************************************************
    // early end drops the last half state
    function automatic logic [3:0] stop_at(input logic [2:0] len, input logic early);
        stop_at = {len, ~early};
    endfunction

    assign gen_start = cur_var ? POS_VAR_START : (cur_io ? POS_IO_START : POS_MEM_START);

    // io strobe opens half a state before the others in variable mode
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            io_request_strobe_n <= RST_PIN_HIGH;
            memory_request_strobe_n <= RST_PIN_HIGH;
            read_strobe_n <= RST_PIN_HIGH;
            write_strobe_n <= RST_PIN_HIGH;
        end else begin
            io_request_strobe_n <= !(in_cyc && cur_io
                && pos >= (cur_var ? POS_VAR_IO_START : POS_IO_START)
                && pos <= stop_at(cur_len, cur_early[EARLY_IO]));
            memory_request_strobe_n <= !(in_cyc && !cur_io && pos >= gen_start
                && pos <= stop_at(cur_len, cur_early[EARLY_MEM]));
            read_strobe_n <= !(state == ST_READ && pos >= gen_start
                && pos <= stop_at(cur_len, cur_early[EARLY_RD]));
            write_strobe_n <= !(state == ST_WRITE && pos >= gen_start
                && pos <= stop_at(cur_len, cur_early[EARLY_WR]));
        end
    end

    // latch at the edge ending the read, hold through the write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_out <= RST_DATA;
            data_oe_n <= RST_PIN_HIGH;
        end else if (state == ST_READ && cyc_end && xfer_en) begin
            data_out <= data_s;
            data_oe_n <= 1'b0;
        end else if (state != ST_WRITE) begin
            data_oe_n <= 1'b1;
        end else if (cyc_end) begin
            data_oe_n <= 1'b1;
        end
    end

    // ****************************************************************
    // commands, interrupt on ready
    // ****************************************************************
    // command register decode for the service sequence
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enabled <= 1'b0;
            after_return_from_interrupt <= 1'b0;
        end else if (cmd_write && cmd_code == CMD_ENABLE_TRANSFER) begin
            enabled <= 1'b1;
        end else if (cmd_write && cmd_code == CMD_ENABLE_AFTER_RETURN_FROM_INTERRUPT) begin
            after_return_from_interrupt <= 1'b1;
        end else if (cmd_write && cmd_code == CMD_DISABLE_TRANSFER) begin
            enabled <= 1'b0;
            after_return_from_interrupt <= 1'b0;
        end else if (return_from_interrupt_seen && in_service_latch) begin
            after_return_from_interrupt <= 1'b0;
        end
    end

    // ready raises the interrupt instead of a request
    // return from interrupt clears in-service and permits one request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            in_service_latch <= 1'b0;
            go_ok <= 1'b0;
        end else begin
            // a request already latched is no new event, so the return can clear it
            if (state == ST_IDLE && int_on_ready && enabled && ready_s && !go_ok
                && !in_service_latch) begin
                in_service_latch <= 1'b1;
            end else if (return_from_interrupt_seen && after_return_from_interrupt) begin
                in_service_latch <= 1'b0;
            end
            if (return_from_interrupt_seen && after_return_from_interrupt && in_service_latch) begin
                go_ok <= 1'b1;
            end else if (state == ST_REQ) begin
                go_ok <= 1'b0;
            end
        end
    end

    // interrupt line only while not holding the bus
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_req_n <= RST_PIN_HIGH;
        end else begin
            int_req_n <= !(in_service_latch && state == ST_IDLE);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // the grant walks from request into the first read state
    sequence s_grant_start;
        state == ST_REQ ##1 state == ST_READ;
    endsequence

    chk_req_next_edge: assert property (@(posedge core_clk) disable iff (rst)
        state == ST_IDLE && t_edge && start_req |=> !bus_request_out_n && state == ST_REQ)
        else $error("request not driven low after ready");
    chk_grant_start: assert property (@(posedge core_clk) disable iff (rst)
        s_grant_start |-> !$past(ack_s_n, 3) && !$past(ack_s_n, 5))
        else $error("transfer began without two acknowledge samples");
    chk_len_ends: assert property (@(posedge core_clk) disable iff (rst)
        cyc_end |-> t == cur_len && t >= LEN_MIN && t <= LEN_MAX)
        else $error("cycle ended at the wrong state");
    chk_no_wait_two: assert property (@(posedge core_clk) disable iff (rst)
        in_cyc && cur_var && cur_len == LEN_MIN |-> !hold_t)
        else $error("two-state cycle was stretched");
    chk_io_lead: assert property (@(posedge core_clk) disable iff (rst)
        $fell(io_request_strobe_n) && $past(cur_var) |=> $fell(read_strobe_n)
        || $fell(write_strobe_n))
        else $error("io strobe did not lead by half a state");
    chk_data_hold: assert property (@(posedge core_clk) disable iff (rst)
        $rose(state == ST_WRITE) && xfer_en |-> !data_oe_n [*2])
        else $error("read data not held into the write");
    chk_park_holds: assert property (@(posedge core_clk) disable iff (rst)
        state == ST_PARK |-> !bus_request_out_n)
        else $error("continuous mode released on not ready");
    chk_eob_release: assert property (@(posedge core_clk) disable iff (rst)
        cyc_end && last_cyc && last_byte && mode != MODE_BYTE |=> bus_request_out_n)
        else $error("end of block did not release");
    chk_int_slave: assert property (@(posedge core_clk) disable iff (rst)
        !int_req_n |-> !bus_master)
        else $error("interrupt driven while bus master");
    chk_match_release: assert property (@(posedge core_clk) disable iff (rst)
        cyc_end && last_cyc && stop_on_match && match_flag && !last_byte
        && mode != MODE_BYTE |=> ##2 bus_request_out_n)
        else $error("match release altered");
    chk_byte_early_rel: assert property (@(posedge core_clk) disable iff (rst)
        byte_done && mode == MODE_BYTE |-> $past(bus_request_out_n))
        else $error("byte mode request not raised before cycle end");
endmodule

// *** verification/dbmt_host_model.sv ***
// host cpu model that grants the bus through the acknowledge chain
`timescale 1ns/10ps
module dbmt_host_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] delay,
    input wire logic bus_request_out_n,
    output logic bus_ack_in_n
);
    // ****************************************
    // grant logic
    // ****************************************
    logic [3:0] cnt;
    // grant by pulling ack low
    // delay lets one run grant promptly and another late
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            bus_ack_in_n <= 1'b1;
        end else if (bus_request_out_n) begin
            cnt <= 4'h0;
            bus_ack_in_n <= 1'b1;
        end else if (cnt == delay) begin
            bus_ack_in_n <= 1'b0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the dma bus-master timing block
`timescale 1ns/10ps
module testbench import dbmt_pkg::*; ();
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ready_pin = 1'b0, wait_n = 1'b1, ready_high = 1'b1, wait_mux_en = 1'b0;
    logic xfer_en = 1'b1, stop_on_match = 1'b0, int_on_ready = 1'b0, src_is_io = 1'b0;
    logic dst_is_io = 1'b0, src_var = 1'b0, dst_var = 1'b0, cmd_write = 1'b0;
    logic return_from_interrupt_seen = 1'b0, match_in = 1'b0, last_byte = 1'b1;
    logic [1:0] mode = MODE_BURST;
    logic [2:0] src_len = LEN_MAX, dst_len = LEN_MAX;
    logic [3:0] src_early = 4'h0, dst_early = 4'h0, delay = 4'h0;
    logic [7:0] data_in = 8'ha5, cmd_code = 8'h00;
    logic bus_request_out_n, bus_ack_out_n, io_request_strobe_n, memory_request_strobe_n;
    logic read_strobe_n, write_strobe_n, data_oe_n, int_req_n, bus_master, byte_done;
    logic in_service_latch, bus_ack_in_n;
    logic [7:0] data_out, lo_def, lo2, lo4, lo4e;
    int failures = 0, n_tests = 0, cycles = 0;

    // 40 ns period
    always #20 core_clk = ~core_clk;

    dbmt_master u_dut (.core_clk, .rst, .ready_pin, .bus_ack_in_n, .wait_n, .data_in,
        .ready_high, .wait_mux_en, .mode, .xfer_en, .stop_on_match, .int_on_ready,
        .src_is_io, .dst_is_io, .src_var, .dst_var, .src_len, .dst_len, .src_early,
        .dst_early, .cmd_write, .cmd_code, .return_from_interrupt_seen, .match_in, .last_byte,
        .bus_request_out_n, .bus_ack_out_n, .io_request_strobe_n, .memory_request_strobe_n,
        .read_strobe_n, .write_strobe_n, .data_out, .data_oe_n, .int_req_n, .bus_master,
        .byte_done, .in_service_latch);
    dbmt_host_model u_host (.core_clk, .rst, .delay, .bus_request_out_n, .bus_ack_in_n);

    // ****************************************
    // helper tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    task automatic end_of_test;
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] c);
        @(posedge core_clk);
        cmd_write <= 1'b1;
        cmd_code <= c;
        @(posedge core_clk);
        cmd_write <= 1'b0;
    endtask

    // bounded wait, sampled at the falling edge where outputs are settled
    task automatic await(ref logic s, input logic v);
        int i;
        i = 0;
        while (s !== v && i < 80) begin
            @(negedge core_clk);
            i++;
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // one byte of a one-byte block in the current mode; returns memory strobe low time
    task automatic run_byte(input logic v, input logic [2:0] len, input logic [3:0] e,
        output logic [7:0] lo);
        lo = 8'h00;
        @(posedge core_clk);
        src_var <= v;
        src_len <= len;
        src_early <= e;
        cmd(CMD_ENABLE_TRANSFER);
        ready_pin <= 1'b1;
        await(memory_request_strobe_n, 1'b0);
        chk("bus_master", 8'h01, {7'h0, bus_master});
        // ready drops inside the last byte
        @(posedge core_clk);
        ready_pin <= 1'b0;
        while (memory_request_strobe_n === 1'b0 && lo < 8'h20) begin
            @(negedge core_clk);
            lo++;
        end
        await(byte_done, 1'b1);
        chk("byte_done", 8'h01, {7'h0, byte_done});
        chk("data_out", 8'ha5, data_out);
        chk("bus_request_out_n", 8'h01, {7'h0, bus_request_out_n});
        chk("data_oe_n", 8'h01, {7'h0, data_oe_n});
        chk("write_strobe_n", 8'h00, {7'h0, write_strobe_n});
        chk("bus_ack_out_n", 8'h01, {7'h0, bus_ack_out_n});
        await(bus_ack_in_n, 1'b1);
    endtask

    // interrupt on ready, then the service command sequence
    task automatic int_ready;
        @(posedge core_clk);
        // io source so the io strobe lead shows on this transfer
        src_is_io <= 1'b1;
        int_on_ready <= 1'b1;
        ready_pin <= 1'b1;
        cmd(CMD_ENABLE_TRANSFER);
        await(int_req_n, 1'b0);
        chk("int_req_n", 8'h00, {7'h0, int_req_n});
        chk("bus_request_out_n", 8'h01, {7'h0, bus_request_out_n});
        cmd(CMD_ENABLE_AFTER_RETURN_FROM_INTERRUPT);
        cmd(CMD_ENABLE_TRANSFER);
        @(posedge core_clk);
        return_from_interrupt_seen <= 1'b1;
        @(posedge core_clk);
        return_from_interrupt_seen <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk("in_service_latch", 8'h00, {7'h0, in_service_latch});
        await(bus_request_out_n, 1'b0);
        chk("bus_request_out_n", 8'h00, {7'h0, bus_request_out_n});
        chk("int_req_n", 8'h01, {7'h0, int_req_n});
        @(posedge core_clk);
        ready_pin <= 1'b0;
        int_on_ready <= 1'b0;
        await(io_request_strobe_n, 1'b0);
        chk("read_strobe_n", 8'h01, {7'h0, read_strobe_n});
        @(negedge core_clk);
        chk("read_strobe_n", 8'h00, {7'h0, read_strobe_n});
        await(bus_request_out_n, 1'b1);
    endtask

    // continuous mode: park on not ready, then release after a match
    task automatic cont_match;
        @(posedge core_clk);
        mode <= MODE_CONTINUOUS;
        stop_on_match <= 1'b1;
        last_byte <= 1'b0;
        ready_pin <= 1'b1;
        await(memory_request_strobe_n, 1'b0);
        @(posedge core_clk);
        ready_pin <= 1'b0;
        await(byte_done, 1'b1);
        repeat (4) @(negedge core_clk);
        chk("bus_request_out_n", 8'h00, {7'h0, bus_request_out_n});
        chk("bus_master", 8'h01, {7'h0, bus_master});
        @(posedge core_clk);
        ready_pin <= 1'b1;
        await(memory_request_strobe_n, 1'b0);
        // ready drops while the match is pending: release timing must not move
        @(posedge core_clk);
        match_in <= 1'b1;
        ready_pin <= 1'b0;
        @(posedge core_clk);
        match_in <= 1'b0;
        await(byte_done, 1'b1);
        chk("bus_request_out_n", 8'h00, {7'h0, bus_request_out_n});
        repeat (2) @(negedge core_clk);
        chk("bus_request_out_n", 8'h01, {7'h0, bus_request_out_n});
        @(posedge core_clk);
        mode <= MODE_BURST;
        stop_on_match <= 1'b0;
        last_byte <= 1'b1;
        await(bus_ack_in_n, 1'b1);
    endtask

    // hang guard, far beyond the expected run length
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk("bus_request_out_n", 8'h01, {7'h0, bus_request_out_n});
        chk("data_out", 8'h00, data_out);
        run_byte(1'b0, LEN_MAX, 4'h0, lo_def);
        chk("mem strobe default", 8'h05, lo_def);
        // wait held low must not stretch two-state variable cycles
        @(posedge core_clk);
        delay <= 4'h6;
        wait_mux_en <= 1'b1;
        wait_n <= 1'b0;
        dst_var <= 1'b1;
        dst_len <= LEN_MIN;
        run_byte(1'b1, LEN_MIN, 4'h0, lo2);
        chk("len2 ignores wait", 8'h03, lo2);
        @(posedge core_clk);
        wait_mux_en <= 1'b0;
        wait_n <= 1'b1;
        dst_var <= 1'b0;
        run_byte(1'b1, LEN_MAX, 4'h0, lo4);
        run_byte(1'b1, LEN_MAX, 4'h4, lo4e);
        chk("len4 minus len2", 8'h04, lo4 - lo2);
        chk("early end saving", 8'h01, lo4 - lo4e);
        @(posedge core_clk);
        mode <= MODE_BYTE;
        run_byte(1'b1, LEN_MAX, 4'h4, lo_def);
        chk("byte mode strobe", 8'h06, lo_def);
        cont_match();
        int_ready();
        end_of_test();
    end
endmodule
